// file: rtl/prc_ctrl.sv
// Overview of operation
// - writing one to bit 15 resets the device like the reset pin, then clears
// - writing one to bit 14 restarts digital logic, registers kept, then clears
// - polarity bit 9 resets from collision pin strap; pull-up means active low
// - source codes 0-3 select link up, any activity, transmit, receive activity
// - codes 4-7 and 10 select collision, speeds, full duplex, 100 full link
// - codes 8,9,11,12 select blink link, stretch, low power idle, MII error
// - code 13 latches on link drop until register one is read
// - code 14 latches on one checker error until self-test status is cleared
// - route 00 drives collision pin, 11 drives first indicator pin, others reserved
// - compliance bit 4 enables short-reach test patterns, resets to zero
// - compliance bits 3:0 choose the transmitted test pattern when enabled
//
// The APB slave port was left to the implementer.
module prc_ctrl #(
    parameter int BLINK_CYCLES = 12_500_000
) (
    input  logic                REF_CLK,
    input  logic                RESETN,
    input  logic                PSEL,
    input  logic                PENABLE,
    input  logic                PWRITE,
    input  logic [7:0]          PADDR,
    input  logic [31:0]         PWDATA,
    output logic [31:0]         PRDATA,
    output logic                PREADY,
    output logic                PSLVERR,
    input  prc_pkg::prc_evt_s   EVENTS,
    input  logic                STATUS_ONE_READ,
    input  logic                SELFTEST_CLEAR,
    input  logic                COL_STRAP_IN,
    output logic                COL_OUT,
    output logic                COL_OE,
    output logic                LED0_OUT,
    output logic                LED0_OE,
    output logic                DEV_RESET_N,
    output logic                DIG_RESTART,
    output prc_pkg::prc_test_s  TEST_CTRL
);
    import prc_pkg::*;

    logic        setup;
    logic        wr_acc;
    logic [5:0]  idx;
    logic        idx_ok;
    logic        sw_start;
    logic        dr_start;
    logic        sw_busy;
    logic        dr_busy;
    logic        strap_sync;
    logic [2:0]  strap_cnt_r;
    logic        pol_r;
    logic [3:0]  src_r;
    logic [1:0]  route_r;
    prc_test_s   test_r;
    logic [31:0] prdata_r;
    logic        pslverr_r;
    logic        link_d_r;
    logic        lost_r;
    logic        prbs_r;
    logic [23:0] blink_cnt_r;
    logic        blink_r;
    logic        evt;
    logic        ind_r;
    logic        col_oe_r;
    logic        led0_oe_r;
    logic        dev_rst_n_r;
    logic        dig_rst_r;

    ////////////////////////////////////////////////////////////////////////////
    // apb decode; zero wait states, so ready is tied high
    assign setup  = PSEL && !PENABLE;
    assign wr_acc = PSEL && PENABLE && PWRITE;
    assign idx    = PADDR[7:2];
    assign idx_ok = (PADDR[1:0] == 2'h0) &&
                    (idx == IDX_RESET_CTRL || idx == IDX_IND_CTRL || idx == IDX_COMPLIANCE);
    assign PREADY = 1'b1;

    assign sw_start = wr_acc && idx_ok && idx == IDX_RESET_CTRL && PWDATA[BIT_SW_RESET];
    assign dr_start = wr_acc && idx_ok && idx == IDX_RESET_CTRL && PWDATA[BIT_DIG_RESTART];

    ////////////////////////////////////////////////////////////////////////////
    // self-clearing operations
    prc_pulse u_sw_reset (
        .clk   (REF_CLK),
        .rst_n (RESETN),
        .start (sw_start),
        .len   (SW_RESET_CYC),
        .busy  (sw_busy)
    );

    prc_pulse u_dig_restart (
        .clk   (REF_CLK),
        .rst_n (RESETN),
        .start (dr_start),
        .len   (DIG_RESTART_CYC),
        .busy  (dr_busy)
    );

    prc_sync u_strap (
        .clk   (REF_CLK),
        .rst_n (RESETN),
        .din   (COL_STRAP_IN),
        .dout  (strap_sync)
    );

    ////////////////////////////////////////////////////////////////////////////
    // strap window reopens after a software reset, as after the pin
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            strap_cnt_r <= '0;
        end else if (sw_busy) begin
            strap_cnt_r <= '0;
        end else if (strap_cnt_r != STRAP_WAIT) begin
            strap_cnt_r <= strap_cnt_r + 1'b1;
        end
    end

    // indicator control register; polarity follows the strap until the window ends
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            pol_r   <= 1'b0;
            src_r   <= IND_SRC_RST;
            route_r <= ROUTE_RST;
        end else if (sw_busy) begin
            src_r   <= IND_SRC_RST;
            route_r <= ROUTE_RST;
        end else if (strap_cnt_r != STRAP_WAIT) begin
            pol_r <= strap_sync;
        end else if (wr_acc && idx_ok && idx == IDX_IND_CTRL) begin
            pol_r   <= PWDATA[BIT_POLARITY];
            src_r   <= PWDATA[SRC_MSB:SRC_LSB];
            route_r <= PWDATA[ROUTE_MSB:ROUTE_LSB];
        end
    end

    // compliance register drives the pattern generator directly
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            test_r <= '{en: TEST_EN_RST, sel: TEST_SEL_RST};
        end else if (sw_busy) begin
            test_r <= '{en: TEST_EN_RST, sel: TEST_SEL_RST};
        end else if (wr_acc && idx_ok && idx == IDX_COMPLIANCE) begin
            test_r.en  <= PWDATA[BIT_TEST_EN];
            test_r.sel <= PWDATA[TEST_SEL_MSB:TEST_SEL_LSB];
        end
    end
    // speed forcing stays with software; the pattern bits pass through as written
    assign TEST_CTRL = test_r;

    ////////////////////////////////////////////////////////////////////////////
    // read data is captured in the setup cycle so it is a flop during access
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            prdata_r  <= '0;
            pslverr_r <= 1'b0;
        end else if (setup) begin
            prdata_r  <= '0;            // reserved bits read zero
            pslverr_r <= !idx_ok;
            if (idx_ok && idx == IDX_RESET_CTRL) begin
                prdata_r[BIT_SW_RESET]    <= sw_busy;
                prdata_r[BIT_DIG_RESTART] <= dr_busy;
            end else if (idx_ok && idx == IDX_IND_CTRL) begin
                prdata_r[BIT_POLARITY]        <= pol_r;
                prdata_r[SRC_MSB:SRC_LSB]     <= src_r;
                prdata_r[ROUTE_MSB:ROUTE_LSB] <= route_r;
            end else if (idx_ok && idx == IDX_COMPLIANCE) begin
                prdata_r[BIT_TEST_EN]                <= test_r.en;
                prdata_r[TEST_SEL_MSB:TEST_SEL_LSB]  <= test_r.sel;
            end
        end
    end
    assign PRDATA  = prdata_r;
    assign PSLVERR = pslverr_r;

    ////////////////////////////////////////////////////////////////////////////
    // sticky indicator sources; the set wins over a clear in the same cycle
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            link_d_r <= 1'b0;
            lost_r   <= 1'b0;
            prbs_r   <= 1'b0;
        end else if (sw_busy || dr_busy) begin
            link_d_r <= 1'b0;
            lost_r   <= 1'b0;
            prbs_r   <= 1'b0;
        end else begin
            link_d_r <= EVENTS.link_up;
            if (link_d_r && !EVENTS.link_up) begin
                lost_r <= 1'b1;
            end else if (STATUS_ONE_READ) begin
                lost_r <= 1'b0;
            end
            if (EVENTS.prbs_err) begin
                prbs_r <= 1'b1;
            end else if (SELFTEST_CLEAR) begin
                prbs_r <= 1'b0;
            end
        end
    end

    // blink divider; a long count, so it is a parameter for simulation
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            blink_cnt_r <= '0;
            blink_r     <= 1'b0;
        end else if (sw_busy || dr_busy) begin
            blink_cnt_r <= '0;
            blink_r     <= 1'b0;
        end else if (blink_cnt_r == 24'(BLINK_CYCLES - 1)) begin
            blink_cnt_r <= '0;
            blink_r     <= !blink_r;
        end else begin
            blink_cnt_r <= blink_cnt_r + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // source select
    always_comb begin
        unique case (src_r)
            SRC_LINK_OK:    evt = EVENTS.link_up;
            SRC_RXTX_ACT:   evt = EVENTS.rx_act || EVENTS.tx_act;
            SRC_TX_ACT:     evt = EVENTS.tx_act;
            SRC_RX_ACT:     evt = EVENTS.rx_act;
            SRC_COLLISION:  evt = EVENTS.collision;
            SRC_SPEED_100:  evt = EVENTS.link_up && EVENTS.speed_100;
            SRC_SPEED_10:   evt = EVENTS.link_up && !EVENTS.speed_100;
            SRC_FULL_DUP:   evt = EVENTS.full_duplex;
            SRC_LINK_BLINK: evt = EVENTS.link_up &&
                                  !((EVENTS.rx_act || EVENTS.tx_act) && blink_r);
            SRC_STRETCH:    evt = EVENTS.stretch;
            SRC_MII_100FD:  evt = EVENTS.link_up && EVENTS.speed_100 &&
                                  EVENTS.full_duplex;
            SRC_LPI:        evt = EVENTS.lpi;
            SRC_MII_ERR:    evt = EVENTS.mii_err;
            SRC_LINK_LOST:  evt = lost_r;
            SRC_PRBS_ERR:   evt = prbs_r;
            default:        evt = 1'b0;     // reserved code stays inactive
        endcase
    end

    // output pins; collision pin released while the strap is sampled or reset runs, first indicator pin only while reset runs
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            ind_r     <= 1'b0;
            col_oe_r  <= 1'b0;
            led0_oe_r <= 1'b0;
        end else begin
            ind_r     <= pol_r ? !evt : evt;
            col_oe_r  <= !sw_busy && strap_cnt_r == STRAP_WAIT &&
                         route_r == ROUTE_COL;
            led0_oe_r <= !sw_busy && route_r == ROUTE_LED0;
        end
    end
    assign COL_OUT  = ind_r;
    assign LED0_OUT = ind_r;
    assign COL_OE   = col_oe_r;
    assign LED0_OE  = led0_oe_r;

    // reset outputs to the rest of the device
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            dev_rst_n_r <= 1'b0;
            dig_rst_r   <= 1'b0;
        end else begin
            dev_rst_n_r <= !sw_start && !sw_busy;
            dig_rst_r   <= dr_start || dr_busy;
        end
    end
    assign DEV_RESET_N = dev_rst_n_r;
    assign DIG_RESTART = dig_rst_r;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESETN);

    // registers return to reset one cycle after the pin output drops
    a_sw_reset_enter: assert property (
        sw_start |=> !DEV_RESET_N ##1 src_r == IND_SRC_RST)
        else $error("software reset did not take effect");
    a_sw_reset_clear: assert property (
        sw_start ##1 !sw_start [*8] ##1 !sw_start [*8] |=> !sw_busy ##1 DEV_RESET_N)
        else $error("software reset did not clear itself");
    a_restart_keeps: assert property (
        dr_start && !sw_start && !sw_busy
        |=> DIG_RESTART && $stable(route_r) && $stable(src_r))
        else $error("digital restart changed registers or did not pulse");
    a_strap_polarity: assert property (
        strap_cnt_r == STRAP_WAIT - 3'h1 && !sw_busy |=> pol_r == $past(strap_sync))
        else $error("polarity not loaded from strap");
    a_link_lost_hold: assert property (lost_r && !STATUS_ONE_READ && !sw_busy && !dr_busy
                                       |=> lost_r)
        else $error("link lost latch dropped without a read");
    a_prbs_latch: assert property (EVENTS.prbs_err && !sw_busy && !dr_busy |=> prbs_r)
        else $error("checker error not latched");
    a_route_col: assert property (route_r == ROUTE_COL && strap_cnt_r == STRAP_WAIT
                                  && !sw_busy |=> COL_OE && !LED0_OE)
        else $error("indicator not routed to collision pin");
    a_test_enable: assert property (wr_acc && idx_ok && idx == IDX_COMPLIANCE && !sw_busy
                                     |=> TEST_CTRL.en == $past(PWDATA[BIT_TEST_EN]))
        else $error("test pattern enable not written");
    a_selfclr_read: assert property (setup && idx == IDX_RESET_CTRL && PADDR[1:0] == 2'h0
                                     && !sw_busy && !dr_busy |=> PRDATA[15:0] == 16'h0000)
        else $error("idle reset register did not read zero");
    a_unmapped_err: assert property (setup && !idx_ok |=> PSLVERR)
        else $error("unmapped address not flagged");

    c_sw_reset:   cover property (sw_start ##[1:40] DEV_RESET_N);
    c_link_lost:  cover property (src_r == SRC_LINK_LOST && lost_r ##[1:20] !lost_r);
    c_prbs_blink: cover property (src_r == SRC_PRBS_ERR && prbs_r && COL_OE);
    c_test_on:    cover property (TEST_CTRL.en && TEST_CTRL.sel != 4'h0);

endmodule

// file: rtl/prc_pkg.sv
package prc_pkg;

    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_RESET_CTRL = 6'h1f;
    localparam logic [5:0] IDX_IND_CTRL   = 6'h25;
    localparam logic [5:0] IDX_COMPLIANCE = 6'h27;

    // field positions
    localparam int BIT_SW_RESET    = 15;
    localparam int BIT_DIG_RESTART = 14;
    localparam int BIT_POLARITY    = 9;
    localparam int SRC_LSB         = 3;
    localparam int SRC_MSB         = 6;
    localparam int ROUTE_LSB       = 0;
    localparam int ROUTE_MSB       = 1;
    localparam int BIT_TEST_EN     = 4;
    localparam int TEST_SEL_LSB    = 0;
    localparam int TEST_SEL_MSB    = 3;

    // reset values
    localparam logic [3:0] IND_SRC_RST  = 4'h0;
    localparam logic [1:0] ROUTE_RST    = 2'h0;
    localparam logic       TEST_EN_RST  = 1'b0;
    localparam logic [3:0] TEST_SEL_RST = 4'h0;

    // routing encodings
    localparam logic [1:0] ROUTE_COL  = 2'h0;
    localparam logic [1:0] ROUTE_LED0 = 2'h3;

    // indicator source encodings
    localparam logic [3:0] SRC_LINK_OK    = 4'h0;
    localparam logic [3:0] SRC_RXTX_ACT   = 4'h1;
    localparam logic [3:0] SRC_TX_ACT     = 4'h2;
    localparam logic [3:0] SRC_RX_ACT     = 4'h3;
    localparam logic [3:0] SRC_COLLISION  = 4'h4;
    localparam logic [3:0] SRC_SPEED_100  = 4'h5;
    localparam logic [3:0] SRC_SPEED_10   = 4'h6;
    localparam logic [3:0] SRC_FULL_DUP   = 4'h7;
    localparam logic [3:0] SRC_LINK_BLINK = 4'h8;
    localparam logic [3:0] SRC_STRETCH    = 4'h9;
    localparam logic [3:0] SRC_MII_100FD  = 4'ha;
    localparam logic [3:0] SRC_LPI        = 4'hb;
    localparam logic [3:0] SRC_MII_ERR    = 4'hc;
    localparam logic [3:0] SRC_LINK_LOST  = 4'hd;
    localparam logic [3:0] SRC_PRBS_ERR   = 4'he;

    // timing counts in cycles of the core clock
    localparam int         PULSE_W         = 5;
    localparam logic [4:0] SW_RESET_CYC    = 5'h10;
    localparam logic [4:0] DIG_RESTART_CYC = 5'h08;
    localparam logic [2:0] STRAP_WAIT      = 3'h5;  // outlasts the four-edge strap synchroniser

    // status from the transceiver core, same clock
    typedef struct packed {
        logic link_up;
        logic rx_act;
        logic tx_act;
        logic collision;
        logic speed_100;
        logic full_duplex;
        logic stretch;
        logic lpi;
        logic mii_err;
        logic prbs_err;
    } prc_evt_s;

    // compliance pattern control towards the transmitter
    typedef struct packed {
        logic       en;
        logic [3:0] sel;
    } prc_test_s;

endpackage

// file: rtl/prc_sync.sv
// three-stage pin synchroniser; output moves once stages two and three agree
module prc_sync (
    input  logic clk,
    input  logic rst_n,
    input  logic din,
    output logic dout
);
    import prc_pkg::*;

    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic dout_r;

    ////////////////////////////////////////////////////////////////////////////
    // stage one feeds only stage two
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r   <= 1'b0;
            s2_r   <= 1'b0;
            s3_r   <= 1'b0;
            dout_r <= 1'b0;
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                dout_r <= s3_r;
            end
        end
    end

    assign dout = dout_r;

endmodule

// file: rtl/prc_pulse.sv
// fixed-length pulse stretcher; busy while the count runs down
module prc_pulse (
    input  logic                        clk,
    input  logic                        rst_n,
    input  logic                        start,
    input  logic [prc_pkg::PULSE_W-1:0] len,
    output logic                        busy
);
    import prc_pkg::*;

    logic [PULSE_W-1:0] cnt_r;

    ////////////////////////////////////////////////////////////////////////////
    // a new start while busy restarts the full length
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
        end else if (start) begin
            cnt_r <= len;
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
        end
    end

    assign busy = (cnt_r != '0);

endmodule

// file: testbench/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import prc_pkg::*;

    localparam logic [7:0] A_RST = {IDX_RESET_CTRL, 2'b00};
    localparam logic [7:0] A_IND = {IDX_IND_CTRL, 2'b00};
    localparam logic [7:0] A_CMP = {IDX_COMPLIANCE, 2'b00};

    logic        ref_clk;
    logic        resetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    prc_evt_s    events;
    logic        status_one_read;
    logic        selftest_clear;
    logic        col_strap_in;
    logic        col_out;
    logic        col_oe;
    logic        led0_out;
    logic        led0_oe;
    logic        dev_reset_n;
    logic        dig_restart;
    prc_test_s   test_ctrl;
    int          error_cnt;
    int          checks_done;

    // short blink period keeps code 1000 observable in a short run
    prc_ctrl #(.BLINK_CYCLES(4)) dut (
        .REF_CLK(ref_clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .EVENTS(events),
        .STATUS_ONE_READ(status_one_read), .SELFTEST_CLEAR(selftest_clear),
        .COL_STRAP_IN(col_strap_in), .COL_OUT(col_out), .COL_OE(col_oe),
        .LED0_OUT(led0_out), .LED0_OE(led0_oe), .DEV_RESET_N(dev_reset_n),
        .DIG_RESTART(dig_restart), .TEST_CTRL(test_ctrl)
    );

    ////////////////////////////////////////////////////////////////////////////
    // clock
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // verdict, reached from the main sequence or a hang
    task automatic give_verdict();
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            chk(32'h1, 32'h0);
            give_verdict();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        e;
        apb(1'b1, a, d, rd, e);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        logic        e;
        apb(1'b0, a, 32'h0, rd, e);
        chk(rd, exp);
        chk({31'h0, e}, 32'h0);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // event level that each source code other than 13 and 14 should show, before polarity
    function automatic logic ev_of(input logic [3:0] s, input prc_evt_s e);
        case (s)
            4'h0: return e.link_up;
            4'h1: return e.rx_act | e.tx_act;
            4'h2: return e.tx_act;
            4'h3: return e.rx_act;
            4'h4: return e.collision;
            4'h5: return e.link_up & e.speed_100;
            4'h6: return e.link_up & ~e.speed_100;
            4'h7: return e.full_duplex;
            4'h8: return e.link_up;
            4'h9: return e.stretch;
            4'ha: return e.link_up & e.speed_100 & e.full_duplex;
            4'hb: return e.lpi;
            4'hc: return e.mii_err;
            default: return 1'b0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        logic [31:0] d;
        logic [31:0] rd;
        logic        e;
        logic        pol;
        logic [1:0]  rt;
        logic [9:0]  evr;
        prc_evt_s    ev;
        int          n;
        resetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        events = '0;
        status_one_read = 1'b0;
        selftest_clear = 1'b0;
        col_strap_in = 1'b1;
        error_cnt = 0;
        checks_done = 0;
        void'($urandom(88476));
        repeat (8) @(posedge ref_clk);
        resetn <= 1'b1;
        tick(10);
        rd_chk(A_RST, 32'h0);
        rd_chk(A_IND, 32'h200);
        rd_chk(A_CMP, 32'h0);
        wr(A_IND, 32'hffff_ffff);
        rd_chk(A_IND, 32'h27b);
        wr(A_RST, 32'h0000_3fff);
        rd_chk(A_RST, 32'h0);
        // compliance fields, corners first then random
        // forcing the speed is left to software before patterns run
        for (int i = 0; i < 6; i++) begin
            d = (i == 0) ? 32'h10 : (i == 1) ? 32'hffef : $urandom;
            wr(A_CMP, d);
            rd_chk(A_CMP, d & 32'h1f);
            chk({27'h0, test_ctrl}, d & 32'h1f);
        end
        // refused accesses: unmapped read, misaligned write
        apb(1'b0, 8'h00, 32'h0, rd, e);
        chk(rd, 32'h0);
        chk({31'h0, e}, 32'h1);
        apb(1'b1, A_CMP + 8'h1, 32'h5, rd, e);
        chk({31'h0, e}, 32'h1);
        rd_chk(A_CMP, d & 32'h1f);
        // every source code except 13 and 14, routes 00 and 11 then random ones, with random events
        for (int s = 0; s < 16; s++) begin
            if (s == 13 || s == 14) continue;
            for (int k = 0; k < 4; k++) begin
                pol = 1'($urandom);
                rt = (k < 2) ? {k[0], k[0]} : 2'($urandom);
                evr = 10'($urandom);
                ev = evr;
                if (s == 8) begin
                    ev.rx_act = 1'b0;
                    ev.tx_act = 1'b0;
                end
                wr(A_IND, {22'h0, pol, 2'b00, 4'(s), 1'b0, rt});
                @(posedge ref_clk);
                events <= ev;
                tick(3);
                chk(col_out, pol ^ ev_of(4'(s), ev));
                chk(led0_out, pol ^ ev_of(4'(s), ev));
                chk({col_oe, led0_oe}, rt == 2'h0 ? 2'b10 : rt == 2'h3 ? 2'b01 : 2'b00);
            end
        end
        // blink on activity: with link and traffic both levels must appear
        wr(A_IND, {22'h0, 1'b0, 2'b00, 4'h8, 1'b0, 2'h3});
        @(posedge ref_clk);
        events <= '{link_up: 1'b1, rx_act: 1'b1, default: 1'b0};
        evr = '0;
        for (int i = 0; i < 12; i++) begin
            tick(1);
            evr[led0_out] = 1'b1;
        end
        chk({30'h0, evr[1:0]}, 32'h3);
        // link-lost latch on the first indicator pin; both latches start cleared
        wr(A_IND, {22'h0, 1'b0, 2'b00, 4'hd, 1'b0, 2'h3});
        @(posedge ref_clk);
        events <= '{link_up: 1'b1, default: 1'b0};
        status_one_read <= 1'b1;
        selftest_clear <= 1'b1;
        @(posedge ref_clk);
        status_one_read <= 1'b0;
        selftest_clear <= 1'b0;
        tick(4);
        chk(led0_out, 1'b0);
        @(posedge ref_clk);
        events.link_up <= 1'b0;
        tick(4);
        chk(led0_out, 1'b1);
        @(posedge ref_clk);
        events.link_up <= 1'b1;
        tick(6);
        chk(led0_out, 1'b1);
        @(posedge ref_clk);
        status_one_read <= 1'b1;
        @(posedge ref_clk);
        status_one_read <= 1'b0;
        tick(3);
        chk(led0_out, 1'b0);
        // one checker error latches until self-test status is cleared
        wr(A_IND, {22'h0, 1'b0, 2'b00, 4'he, 1'b0, 2'h3});
        tick(3);
        chk(led0_out, 1'b0);
        @(posedge ref_clk);
        events.prbs_err <= 1'b1;
        @(posedge ref_clk);
        events.prbs_err <= 1'b0;
        tick(8);
        chk(led0_out, 1'b1);
        // error and clear in one cycle: the error wins
        @(posedge ref_clk);
        events.prbs_err <= 1'b1;
        selftest_clear <= 1'b1;
        @(posedge ref_clk);
        events.prbs_err <= 1'b0;
        selftest_clear <= 1'b0;
        tick(3);
        chk(led0_out, 1'b1);
        @(posedge ref_clk);
        selftest_clear <= 1'b1;
        @(posedge ref_clk);
        selftest_clear <= 1'b0;
        tick(3);
        chk(led0_out, 1'b0);
        // digital restart keeps registers and clears itself
        wr(A_CMP, 32'h15);
        wr(A_RST, 32'h4000);
        n = 0;
        while (dig_restart !== 1'b1 && n < 4) begin tick(1); n++; end
        chk(dig_restart, 1'b1);
        rd_chk(A_RST, 32'h4000);
        n = 0;
        while (dig_restart !== 1'b0 && n < 30) begin tick(1); n++; end
        rd_chk(A_RST, 32'h0);
        rd_chk(A_CMP, 32'h15);
        // software reset with strap now pulled down; writes meanwhile ignored
        col_strap_in <= 1'b0;
        tick(6);
        wr(A_RST, 32'h8000);
        n = 0;
        while (dev_reset_n !== 1'b0 && n < 4) begin tick(1); n++; end
        chk(dev_reset_n, 1'b0);
        wr(A_CMP, 32'h1f);
        n = 0;
        while (dev_reset_n !== 1'b1 && n < 40) begin tick(1); n++; end
        chk(dev_reset_n, 1'b1);
        tick(8);
        rd_chk(A_CMP, 32'h0);
        rd_chk(A_IND, 32'h0);
        rd_chk(A_RST, 32'h0);
        chk({27'h0, test_ctrl}, 32'h0);
        give_verdict();
    end

    // hang guard
    initial begin
        #200000;
        error_cnt++;
        $display("ERROR %0t: run timed out", $time);
        give_verdict();
    end
endmodule
